// [pkg/ccsr_defines.svh]
`ifndef CCSR_DEFINES_SVH
`define CCSR_DEFINES_SVH

// ==========================================================================
// register offsets
`define CCSR_OFS_STACK_PTR    8'h81
`define CCSR_OFS_PTR_LOW      8'h82
`define CCSR_OFS_PTR_HIGH     8'h83
`define CCSR_OFS_STATUS       8'hD0
`define CCSR_OFS_PRIMARY      8'hE0
`define CCSR_OFS_SECONDARY    8'hF0
`define CCSR_OFS_AUX_CTRL     8'hF8

// ==========================================================================
// reset values
`define CCSR_RST_STACK_PTR    8'h07
`define CCSR_RST_BYTE         8'h00

// ==========================================================================
// status word field positions
`define CCSR_SW_CARRY         7
`define CCSR_SW_HALF          6
`define CCSR_SW_UFLAG0        5
`define CCSR_SW_BANK_HI       4
`define CCSR_SW_BANK_LO       3
`define CCSR_SW_OVER          2
`define CCSR_SW_UFLAG1        1
`define CCSR_SW_PARITY        0

// auxiliary control field position
`define CCSR_AUX_PTR_SEL      0

// decimal adjust limits and corrections
`define CCSR_DA_LIMIT         4'h9
`define CCSR_DA_LOW_ADD       8'h06
`define CCSR_DA_HIGH_ADD      8'h60

// bytes moved on the stack by a call or return
`define CCSR_CALL_BYTES       8'h02

`endif

// [pkg/ccsr_pkg.sv]
package ccsr_pkg;

   // ========================================================================
   // instruction classes that the decoder hands to the register set
   typedef enum logic [4:0]
   {
      CCSR_OP_NOP   = 5'h00,
      CCSR_OP_ADD   = 5'h01,
      CCSR_OP_ADDC  = 5'h02,
      CCSR_OP_SUBB  = 5'h03,
      CCSR_OP_MUL   = 5'h04,
      CCSR_OP_DIV   = 5'h05,
      CCSR_OP_DA    = 5'h06,
      CCSR_OP_RRC   = 5'h07,
      CCSR_OP_RLC   = 5'h08,
      CCSR_OP_SETC  = 5'h09,
      CCSR_OP_CLRC  = 5'h0A,
      CCSR_OP_CPLC  = 5'h0B,
      CCSR_OP_ANLC  = 5'h0C,
      CCSR_OP_ANLCN = 5'h0D,
      CCSR_OP_ORLC  = 5'h0E,
      CCSR_OP_ORLCN = 5'h0F,
      CCSR_OP_MOVCB = 5'h10,
      CCSR_OP_CJNE  = 5'h11,
      CCSR_OP_PUSH  = 5'h12,
      CCSR_OP_POP   = 5'h13,
      CCSR_OP_CALL  = 5'h14,
      CCSR_OP_RET   = 5'h15,
      CCSR_OP_LDA   = 5'h16
   } ccsr_op_e;

   // ========================================================================
   // request from the decoder
   typedef struct packed
   {
      logic       valid;
      ccsr_op_e   op;
      logic [7:0] operand;
      logic [7:0] cmp_left;
      logic       bit_val;
   } ccsr_op_s;

   // register port request
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccsr_bus_s;

endpackage : ccsr_pkg

// [design/ccsr_core_regs.sv]
// The plain strobed port was chosen for this implementation.
`include "ccsr_defines.svh"

// Function
// - primary operand register feeds alu, holds results, 8-bit, resets zero
// - secondary register is second multiply/divide operand, else scratch byte
// - divide puts quotient of primary by secondary into primary
// - stack pointer addresses top entry, 8 bits, resets to seven
// - calls store program counter on stack, returns reload it
// - push increments stack pointer, pop decrements it
// - two 16-bit data pointers of low and high bytes, reset zero
// - both pointers share addresses; aux control bit 0 selects one
// - selected pointer addresses external data, code fetch and indirect jump
// - add/addc/subb set carry, overflow, half carry; da/rotates/cjne carry only
// - mul/div clear carry, set overflow; carry bit ops set carry
// - set-carry forces carry to one, other flags untouched
// - status word layout carry..parity, all bits reset zero
// - bank select maps r0-r7 onto ram bytes 00h-1Fh in eights
// - parity flag follows odd count of ones in primary register
module ccsr_core_regs
(
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_srst,
   // register port
   input  wire ccsr_pkg::ccsr_bus_s i_bus,
   output logic [7:0]               o_rdata,
   // decoder request
   input  wire ccsr_pkg::ccsr_op_s  i_op,
   // core facing state
   output logic [7:0]               o_primary,
   output logic [7:0]               o_secondary,
   output logic [7:0]               o_call_stack_pointer,
   output logic [15:0]              o_data_pointer_pair,
   output logic [7:0]               o_status_word,
   output logic [7:0]               o_bank_base
);
   import ccsr_pkg::*;

   // ========================================================================
   // state
   logic [7:0] acc_r;
   logic [7:0] sec_r;
   logic [7:0] sp_r;
   logic       cy_r;
   logic       ac_r;
   logic       f0_r;
   logic [1:0] rs_r;
   logic       ov_r;
   logic       f1_r;
   logic       sel_r;
   logic [7:0] dpl_r [2];
   logic [7:0] dph_r [2];
   logic [7:0] rdata_r;

   logic [7:0] acc_nxt;
   logic [7:0] sec_nxt;
   logic [7:0] sp_nxt;
   logic       cy_nxt;
   logic       ac_nxt;
   logic       ov_nxt;
   logic       f0_nxt;
   logic [1:0] rs_nxt;
   logic       f1_nxt;

   logic       wr_acc;
   logic       wr_sec;
   logic       wr_sp;
   logic       wr_sw;
   logic       wr_dpl;
   logic       wr_dph;
   logic       wr_aux;

   logic [8:0]  sum9;
   logic [4:0]  sum5;
   logic [8:0]  dif9;
   logic [4:0]  dif5;
   logic [15:0] prod;
   logic [7:0]  quot;
   logic [7:0]  rem;
   logic [8:0]  da_lo;
   logic [8:0]  da_hi;
   logic [7:0]  sw_view;
   logic        addc_in;

   // ========================================================================
   // register decode
   always_comb
   begin
      wr_acc = 1'b0;
      wr_sec = 1'b0;
      wr_sp  = 1'b0;
      wr_sw  = 1'b0;
      wr_dpl = 1'b0;
      wr_dph = 1'b0;
      wr_aux = 1'b0;
      if (i_bus.addr == `CCSR_OFS_PRIMARY)
         wr_acc = i_bus.wr;
      else if (i_bus.addr == `CCSR_OFS_SECONDARY)
         wr_sec = i_bus.wr;
      else if (i_bus.addr == `CCSR_OFS_STACK_PTR)
         wr_sp = i_bus.wr;
      else if (i_bus.addr == `CCSR_OFS_STATUS)
         wr_sw = i_bus.wr;
      else if (i_bus.addr == `CCSR_OFS_PTR_LOW)
         wr_dpl = i_bus.wr;
      else if (i_bus.addr == `CCSR_OFS_PTR_HIGH)
         wr_dph = i_bus.wr;
      else if (i_bus.addr == `CCSR_OFS_AUX_CTRL)
         wr_aux = i_bus.wr;
   end

   // ========================================================================
   // arithmetic datapath
   assign addc_in = (i_op.op == CCSR_OP_ADDC) ? cy_r : 1'b0;
   assign sum9  = {1'b0, acc_r} + {1'b0, i_op.operand} + {8'h00, addc_in};
   assign sum5  = {1'b0, acc_r[3:0]} + {1'b0, i_op.operand[3:0]} + {4'h0, addc_in};
   assign dif9  = {1'b0, acc_r} - {1'b0, i_op.operand} - {8'h00, cy_r};
   assign dif5  = {1'b0, acc_r[3:0]} - {1'b0, i_op.operand[3:0]} - {4'h0, cy_r};
   assign prod  = acc_r * sec_r;
   // a zero divisor leaves both operands as they were and flags overflow
   assign quot  = (sec_r == 8'h00) ? acc_r : acc_r / sec_r;
   assign rem   = (sec_r == 8'h00) ? sec_r : acc_r % sec_r;
   assign da_lo = ((acc_r[3:0] > `CCSR_DA_LIMIT) || ac_r) ?
                  {1'b0, acc_r} + {1'b0, `CCSR_DA_LOW_ADD} : {1'b0, acc_r};
   assign da_hi = ((da_lo[7:4] > `CCSR_DA_LIMIT) || cy_r || da_lo[8]) ?
                  {1'b0, da_lo[7:0]} + {1'b0, `CCSR_DA_HIGH_ADD} : da_lo;

   // ========================================================================
   // next state: software writes first, instruction effects override them
   always_comb
   begin
      acc_nxt = wr_acc ? i_bus.wdata : acc_r;
      sec_nxt = wr_sec ? i_bus.wdata : sec_r;
      sp_nxt  = wr_sp  ? i_bus.wdata : sp_r;
      cy_nxt  = wr_sw  ? i_bus.wdata[`CCSR_SW_CARRY] : cy_r;
      ac_nxt  = wr_sw  ? i_bus.wdata[`CCSR_SW_HALF] : ac_r;
      ov_nxt  = wr_sw  ? i_bus.wdata[`CCSR_SW_OVER] : ov_r;
      f0_nxt  = wr_sw  ? i_bus.wdata[`CCSR_SW_UFLAG0] : f0_r;
      f1_nxt  = wr_sw  ? i_bus.wdata[`CCSR_SW_UFLAG1] : f1_r;
      rs_nxt  = wr_sw  ? i_bus.wdata[`CCSR_SW_BANK_HI:`CCSR_SW_BANK_LO] : rs_r;
      if (i_op.valid)
      begin
         case (i_op.op)
            CCSR_OP_ADD, CCSR_OP_ADDC:
            begin
               acc_nxt = sum9[7:0];
               cy_nxt  = sum9[8];
               ac_nxt  = sum5[4];
               ov_nxt  = (acc_r[7] == i_op.operand[7]) && (sum9[7] != acc_r[7]);
            end
            CCSR_OP_SUBB:
            begin
               acc_nxt = dif9[7:0];
               cy_nxt  = dif9[8];
               ac_nxt  = dif5[4];
               ov_nxt  = (acc_r[7] != i_op.operand[7]) && (dif9[7] != acc_r[7]);
            end
            CCSR_OP_MUL:
            begin
               acc_nxt = prod[7:0];
               sec_nxt = prod[15:8];
               cy_nxt  = 1'b0;
               ov_nxt  = (prod[15:8] != 8'h00);
            end
            CCSR_OP_DIV:
            begin
               acc_nxt = quot;
               sec_nxt = rem;
               cy_nxt  = 1'b0;
               ov_nxt  = (sec_r == 8'h00);
            end
            CCSR_OP_DA:
            begin
               acc_nxt = da_hi[7:0];
               cy_nxt  = cy_r | da_lo[8] | da_hi[8];
            end
            CCSR_OP_RRC:
            begin
               acc_nxt = {cy_r, acc_r[7:1]};
               cy_nxt  = acc_r[0];
            end
            CCSR_OP_RLC:
            begin
               acc_nxt = {acc_r[6:0], cy_r};
               cy_nxt  = acc_r[7];
            end
            CCSR_OP_CJNE:
               cy_nxt  = (i_op.cmp_left < i_op.operand);
            CCSR_OP_SETC:
               cy_nxt  = 1'b1;
            CCSR_OP_CLRC:
               cy_nxt  = 1'b0;
            CCSR_OP_CPLC:
               cy_nxt  = ~cy_r;
            CCSR_OP_ANLC:
               cy_nxt  = cy_r & i_op.bit_val;
            CCSR_OP_ANLCN:
               cy_nxt  = cy_r & ~i_op.bit_val;
            CCSR_OP_ORLC:
               cy_nxt  = cy_r | i_op.bit_val;
            CCSR_OP_ORLCN:
               cy_nxt  = cy_r | ~i_op.bit_val;
            CCSR_OP_MOVCB:
               cy_nxt  = i_op.bit_val;
            CCSR_OP_PUSH:
               sp_nxt  = sp_r + 8'h01;
            CCSR_OP_POP:
               sp_nxt  = sp_r - 8'h01;
            // both program counter bytes sit on the stack
            CCSR_OP_CALL:
               sp_nxt  = sp_r + `CCSR_CALL_BYTES;
            CCSR_OP_RET:
               sp_nxt  = sp_r - `CCSR_CALL_BYTES;
            CCSR_OP_LDA:
               acc_nxt = i_op.operand;
            default:
               ;
         endcase
      end
   end

   // ========================================================================
   // operand registers
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         acc_r <= `CCSR_RST_BYTE;
         sec_r <= `CCSR_RST_BYTE;
      end
      else
      begin
         acc_r <= acc_nxt;
         sec_r <= sec_nxt;
      end
   end

   // stack pointer
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         sp_r <= `CCSR_RST_STACK_PTR;
      else
         sp_r <= sp_nxt;
   end

   // status word flags
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         cy_r <= 1'b0;
         ac_r <= 1'b0;
         f0_r <= 1'b0;
         rs_r <= 2'h0;
         ov_r <= 1'b0;
         f1_r <= 1'b0;
      end
      else
      begin
         cy_r <= cy_nxt;
         ac_r <= ac_nxt;
         f0_r <= f0_nxt;
         rs_r <= rs_nxt;
         ov_r <= ov_nxt;
         f1_r <= f1_nxt;
      end
   end

   // pointer select
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         sel_r <= 1'b0;
      else if (wr_aux)
         sel_r <= i_bus.wdata[`CCSR_AUX_PTR_SEL];
   end

   // ========================================================================
   // dual data pointers, one shared address pair
   for (genvar g = 0; g < 2; g++)
   begin : g_ptr
      always_ff @(posedge i_clk)
      begin
         if (i_srst)
         begin
            dpl_r[g] <= `CCSR_RST_BYTE;
            dph_r[g] <= `CCSR_RST_BYTE;
         end
         else if (sel_r == 1'(g))
         begin
            if (wr_dpl)
               dpl_r[g] <= i_bus.wdata;
            if (wr_dph)
               dph_r[g] <= i_bus.wdata;
         end
      end
   end

   // ========================================================================
   // parity is derived live so it can never lag the primary register
   assign sw_view = {cy_r, ac_r, f0_r, rs_r, ov_r, f1_r, ^acc_r};

   // read data stands for one cycle only, unmapped reads return zero
   always_ff @(posedge i_clk)
   begin
      if (i_srst || !i_bus.rd)
         rdata_r <= 8'h00;
      else if (i_bus.addr == `CCSR_OFS_PRIMARY)
         rdata_r <= acc_r;
      else if (i_bus.addr == `CCSR_OFS_SECONDARY)
         rdata_r <= sec_r;
      else if (i_bus.addr == `CCSR_OFS_STACK_PTR)
         rdata_r <= sp_r;
      else if (i_bus.addr == `CCSR_OFS_STATUS)
         rdata_r <= sw_view;
      else if (i_bus.addr == `CCSR_OFS_PTR_LOW)
         rdata_r <= dpl_r[sel_r];
      else if (i_bus.addr == `CCSR_OFS_PTR_HIGH)
         rdata_r <= dph_r[sel_r];
      else if (i_bus.addr == `CCSR_OFS_AUX_CTRL)
         rdata_r <= {7'h00, sel_r};
      else
         rdata_r <= 8'h00;
   end

   // ========================================================================
   // outputs
   assign o_rdata              = rdata_r;
   assign o_primary            = acc_r;
   assign o_secondary          = sec_r;
   assign o_call_stack_pointer = sp_r;
   assign o_data_pointer_pair  = {dph_r[sel_r], dpl_r[sel_r]};
   assign o_status_word        = sw_view;
   assign o_bank_base          = {3'h0, rs_r, 3'h0};

   // ========================================================================
   // checks
   property p_sp_reset;
      @(posedge i_clk) i_srst |=> (sp_r == 8'h07) && (acc_r == 8'h00);
   endproperty
   a_sp_reset : assert property (p_sp_reset) else $error("reset values wrong");

   property p_push;
      @(posedge i_clk) disable iff (i_srst)
      (i_op.valid && i_op.op == CCSR_OP_PUSH) |=> sp_r == $past(sp_r) + 8'h01;
   endproperty
   a_push : assert property (p_push) else $error("push did not increment");

   property p_call;
      @(posedge i_clk) disable iff (i_srst)
      (i_op.valid && i_op.op == CCSR_OP_CALL) |=> sp_r == $past(sp_r) + 8'h02;
   endproperty
   a_call : assert property (p_call) else $error("call stack step wrong");

   property p_div;
      @(posedge i_clk) disable iff (i_srst)
      (i_op.valid && i_op.op == CCSR_OP_DIV && sec_r != 8'h00) |=>
         (acc_r == $past(acc_r) / $past(sec_r)) && !cy_r && !ov_r;
   endproperty
   a_div : assert property (p_div) else $error("divide result wrong");

   property p_mul;
      @(posedge i_clk) disable iff (i_srst)
      (i_op.valid && i_op.op == CCSR_OP_MUL) |=>
         ({sec_r, acc_r} == $past(acc_r) * $past(sec_r)) && !cy_r &&
         (ov_r == (sec_r != 8'h00));
   endproperty
   a_mul : assert property (p_mul) else $error("multiply result wrong");

   property p_setc;
      @(posedge i_clk) disable iff (i_srst)
      (i_op.valid && i_op.op == CCSR_OP_SETC && !(i_bus.wr && i_bus.addr == 8'hD0)) |=>
         cy_r && $stable(ac_r) && $stable(ov_r);
   endproperty
   a_setc : assert property (p_setc) else $error("set carry disturbed flags");

   property p_parity;
      @(posedge i_clk) disable iff (i_srst)
      (i_bus.rd && i_bus.addr == 8'hD0) |=> o_rdata[0] == ^$past(acc_r);
   endproperty
   a_parity : assert property (p_parity) else $error("parity flag wrong");

   property p_ptr_iso;
      @(posedge i_clk) disable iff (i_srst)
      (i_bus.wr && i_bus.addr == 8'h82 && !sel_r) |=> $stable(dpl_r[1]) &&
         (dpl_r[0] == $past(i_bus.wdata));
   endproperty
   a_ptr_iso : assert property (p_ptr_iso) else $error("pointer bank leak");

   property p_bank;
      @(posedge i_clk) disable iff (i_srst)
      (i_bus.wr && i_bus.addr == 8'hD0 && !i_op.valid) |=>
         o_bank_base[4:3] == $past(i_bus.wdata[4:3]);
   endproperty
   a_bank : assert property (p_bank) else $error("bank base wrong");

endmodule : ccsr_core_regs

// [sim/ccsr_decoder_model.sv]
module ccsr_decoder_model
(
   // clock
   input  wire logic          i_clk,
   // instruction request toward the register set
   output ccsr_pkg::ccsr_op_s o_op
);
   timeunit 1ns;
   timeprecision 1ps;

   import ccsr_pkg::*;

   initial o_op = '0;

   // =======================================================================
   // instruction issue
   // one instruction per call; valid is a single cycle pulse, as the core's
   // decoder issues it. once valid drops the operand fields are no longer
   // meaningful, so they flip to the inverse rather than hold a stale value
   task automatic issue(input ccsr_op_e op, input logic [7:0] operand,
                        input logic [7:0] left, input logic bit_val);
      @(posedge i_clk);
      o_op <= '{1'b1, op, operand, left, bit_val};
      @(posedge i_clk);
      o_op <= '{1'b0, CCSR_OP_NOP, ~operand, ~left, ~bit_val};
   endtask : issue

endmodule : ccsr_decoder_model

// [sim/ccsr_core_regs_test.sv]
module ccsr_core_regs_test;
   timeunit 1ns;
   timeprecision 1ps;

   import ccsr_pkg::*;

   // =======================================================================
   // signals
   logic               i_clk;
   logic               i_srst;
   ccsr_bus_s          bus;
   ccsr_op_s           op;
   logic [7:0]         rdata;
   logic [7:0]         primary;
   logic [7:0]         secondary;
   logic [7:0]         stack_ptr;
   logic [15:0]        data_pointer_pair;
   logic [7:0]         status;
   logic [7:0]         bank_base;
   int                 errors;
   int                 check_count;
   int                 cycles = 0;

   ccsr_core_regs i_ccsr_core_regs
   (
      .i_clk                (i_clk),
      .i_srst               (i_srst),
      .i_bus                (bus),
      .o_rdata              (rdata),
      .i_op                 (op),
      .o_primary            (primary),
      .o_secondary          (secondary),
      .o_call_stack_pointer (stack_ptr),
      .o_data_pointer_pair  (data_pointer_pair),
      .o_status_word        (status),
      .o_bank_base          (bank_base)
   );

   ccsr_decoder_model i_ccsr_decoder_model
   (
      .i_clk (i_clk),
      .o_op  (op)
   );

   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   // =======================================================================
   // reporting
   task automatic test_done();
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // the whole run needs under 150 cycles; this only catches a hang
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         errors++;
         test_done();
      end
   end

   // =======================================================================
   // bus and instruction helpers
   task automatic do_reset();
      @(posedge i_clk);
      i_srst <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
   endtask : do_reset

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge i_clk);
      bus.wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_clk);
      bus.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_chk

   task automatic op_chk(input ccsr_op_e c, input logic [7:0] v, input logic [7:0] left,
                         input logic b, input logic [7:0] exp_acc, input logic [7:0] exp_sw);
      i_ccsr_decoder_model.issue(c, v, left, b);
      #1 chk(primary, exp_acc);
      chk(status, exp_sw);
   endtask : op_chk

   // =======================================================================
   // scenarios
   task automatic t_reset_values();
      rd_chk(8'h81, 8'h07);
      rd_chk(8'h82, 8'h00);
      rd_chk(8'h83, 8'h00);
      rd_chk(8'hD0, 8'h00);
      rd_chk(8'hE0, 8'h00);
      rd_chk(8'hF0, 8'h00);
      rd_chk(8'hF8, 8'h00);
      rd_chk(8'h55, 8'h00);
      chk(bank_base, 8'h00);
   endtask : t_reset_values

   task automatic t_arith();
      op_chk(CCSR_OP_LDA, 8'h7F, 8'h00, 1'b0, 8'h7F, 8'h01);
      op_chk(CCSR_OP_ADD, 8'h01, 8'h00, 1'b0, 8'h80, 8'h45);
      op_chk(CCSR_OP_ADD, 8'h80, 8'h00, 1'b0, 8'h00, 8'h84);
      op_chk(CCSR_OP_ADDC, 8'h00, 8'h00, 1'b0, 8'h01, 8'h01);
      op_chk(CCSR_OP_SUBB, 8'h02, 8'h00, 1'b0, 8'hFF, 8'hC0);
   endtask : t_arith

   task automatic t_mul_div();
      op_chk(CCSR_OP_LDA, 8'h10, 8'h00, 1'b0, 8'h10, 8'hC1);
      wr_reg(8'hF0, 8'h20);
      wr_reg(8'hD0, 8'h00);
      op_chk(CCSR_OP_MUL, 8'h00, 8'h00, 1'b0, 8'h00, 8'h04);
      chk(secondary, 8'h02);
      op_chk(CCSR_OP_LDA, 8'h64, 8'h00, 1'b0, 8'h64, 8'h05);
      wr_reg(8'hF0, 8'h07);
      wr_reg(8'hD0, 8'h80);
      op_chk(CCSR_OP_DIV, 8'h00, 8'h00, 1'b0, 8'h0E, 8'h01);
      chk(secondary, 8'h02);
      wr_reg(8'hF0, 8'h00);
      op_chk(CCSR_OP_DIV, 8'h00, 8'h00, 1'b0, 8'h0E, 8'h05);
   endtask : t_mul_div

   // accumulator holds 0E here; half carry and overflow are set and must stay
   task automatic t_carry_ops();
      wr_reg(8'hD0, 8'h44);
      op_chk(CCSR_OP_SETC, 8'h00, 8'h00, 1'b0, 8'h0E, 8'hC5);
      op_chk(CCSR_OP_CLRC, 8'h00, 8'h00, 1'b0, 8'h0E, 8'h45);
      op_chk(CCSR_OP_CPLC, 8'h00, 8'h00, 1'b0, 8'h0E, 8'hC5);
      op_chk(CCSR_OP_ANLC, 8'h00, 8'h00, 1'b0, 8'h0E, 8'h45);
      op_chk(CCSR_OP_ORLC, 8'h00, 8'h00, 1'b1, 8'h0E, 8'hC5);
      op_chk(CCSR_OP_ANLCN, 8'h00, 8'h00, 1'b1, 8'h0E, 8'h45);
      op_chk(CCSR_OP_ORLCN, 8'h00, 8'h00, 1'b0, 8'h0E, 8'hC5);
      op_chk(CCSR_OP_MOVCB, 8'h00, 8'h00, 1'b0, 8'h0E, 8'h45);
      op_chk(CCSR_OP_CJNE, 8'h03, 8'h05, 1'b0, 8'h0E, 8'h45);
      op_chk(CCSR_OP_CJNE, 8'h05, 8'h03, 1'b0, 8'h0E, 8'hC5);
      op_chk(CCSR_OP_RRC, 8'h00, 8'h00, 1'b0, 8'h87, 8'h44);
      op_chk(CCSR_OP_RLC, 8'h00, 8'h00, 1'b0, 8'h0E, 8'hC5);
      op_chk(CCSR_OP_LDA, 8'h9A, 8'h00, 1'b0, 8'h9A, 8'hC4);
      op_chk(CCSR_OP_DA, 8'h00, 8'h00, 1'b0, 8'h00, 8'hC4);
   endtask : t_carry_ops

   task automatic t_stack();
      i_ccsr_decoder_model.issue(CCSR_OP_CALL, 8'h00, 8'h00, 1'b0);
      #1 chk(stack_ptr, 8'h09);
      i_ccsr_decoder_model.issue(CCSR_OP_PUSH, 8'h00, 8'h00, 1'b0);
      #1 chk(stack_ptr, 8'h0A);
      i_ccsr_decoder_model.issue(CCSR_OP_POP, 8'h00, 8'h00, 1'b0);
      #1 chk(stack_ptr, 8'h09);
      i_ccsr_decoder_model.issue(CCSR_OP_RET, 8'h00, 8'h00, 1'b0);
      #1 chk(stack_ptr, 8'h07);
      wr_reg(8'h81, 8'h30);
      rd_chk(8'h81, 8'h30);
   endtask : t_stack

   task automatic t_pointers();
      wr_reg(8'h82, 8'h34);
      wr_reg(8'h83, 8'h12);
      wr_reg(8'hF8, 8'h01);
      #1 chk(data_pointer_pair[7:0], 8'h00);
      wr_reg(8'h82, 8'hCD);
      wr_reg(8'h83, 8'hAB);
      #1 chk(data_pointer_pair[15:8], 8'hAB);
      rd_chk(8'h82, 8'hCD);
      wr_reg(8'hF8, 8'h00);
      #1 chk(data_pointer_pair[15:8], 8'h12);
      chk(data_pointer_pair[7:0], 8'h34);
      rd_chk(8'h83, 8'h12);
      wr_reg(8'hF8, 8'hFF);
      rd_chk(8'hF8, 8'h01);
      chk(data_pointer_pair[7:0], 8'hCD);
   endtask : t_pointers

   // an instruction result must win over a bus write in the same cycle
   task automatic t_collision_and_banks();
      fork
         wr_reg(8'hE0, 8'h55);
         i_ccsr_decoder_model.issue(CCSR_OP_LDA, 8'h33, 8'h00, 1'b0);
      join
      #1 chk(primary, 8'h33);
      wr_reg(8'hE0, 8'h5A);
      #1 chk(primary, 8'h5A);
      for (int b = 0; b < 4; b++)
      begin
         wr_reg(8'hD0, {3'b001, 2'(b), 3'b011});
         rd_chk(8'hD0, {3'b001, 2'(b), 3'b010});
         chk(bank_base, {3'b000, 2'(b), 3'b000});
      end
   endtask : t_collision_and_banks

   task automatic t_mid_reset();
      do_reset();
      #1 chk(stack_ptr, 8'h07);
      chk(status, 8'h00);
      chk(primary, 8'h00);
      chk(bank_base, 8'h00);
      chk(data_pointer_pair[7:0], 8'h00);
   endtask : t_mid_reset

   // =======================================================================
   // main sequence
   initial
   begin
      errors = 0;
      check_count = 0;
      bus = '0;
      i_srst = 1'b1;
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      t_reset_values();
      t_arith();
      t_mul_div();
      t_carry_ops();
      t_stack();
      t_pointers();
      t_collision_and_banks();
      t_mid_reset();
      test_done();
   end

endmodule : ccsr_core_regs_test
